/* File: rtl/ssr_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - The suspend refresh mode resets to 00, SRAM, which makes no refresh activity.
// - PSRAM mode asserts the first then the second refresh select and leaves row strobes high.
// - Standard DRAM mode asserts both selects in order and pulses both row strobes per interval.
// - Self-refresh DRAM mode asserts both selects, then row strobe one, then two, and holds.
// - The slow refresh bit resets to 0 and picks 15 us when clear and 120 us when set.
// - The refresh complete flag resets to 0 and reads 0 while suspend refresh is running.
// - The refresh complete flag reads 1 once the memory controller owns refresh again.
// - The four low bits of the suspend refresh control register reset and read as zero.
// - The shadow base register gives address bits 23 to 16 and resets to 0FH.
// - The shadow region may sit on any 64 Kbyte boundary of the 16 Mbyte space.
// - With write enable set, writes to F0000H-FFFFFH go to shadow RAM, else to ROM.
// - With read enable set, reads of the BIOS range go to shadow RAM, else to ROM.
module ssr_ctrl
(
   input  wire logic        ref_clk_in,
   input  wire logic        resetn_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic [7:0]       reg_rdata_out,
   input  wire logic        suspend_in,
   input  wire logic        mem_req_in,
   input  wire logic        mem_write_in,
   input  wire logic [23:0] mem_addr_in,
   output logic [23:0]      mem_addr_out,
   output logic             rom_sel_out,
   output logic             ram_sel_out,
   output logic             eseg_wp_out,
   output logic             dseg_wp_out,
   output logic             refresh_select_n_out,
   output logic             second_refresh_select_n_out,
   output logic             row_strobe_n_out,
   output logic             second_row_strobe_n_out,
   output logic             refresh_complete_out,
   output logic             irq_out
);
   import ssr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Register state.
   ssr_mode_t                suspend_refresh_mode_reg;
   logic                     slow_refresh_select_reg;
   logic                     refresh_complete_flag_reg;
   logic [7:0]               shadow_base_bits_reg;
   logic                     shadow_write_enable_reg;
   logic                     shadow_read_enable_reg;
   logic                     eseg_wp_reg;
   logic                     dseg_wp_reg;
   logic [IRQ_WIDTH-1:0]     irq_status_reg;
   logic [IRQ_WIDTH-1:0]     irq_mask_reg;
   logic [7:0]               rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer state.
   ssr_state_t               state_reg;
   ssr_state_t               state_next;
   ssr_mode_t                run_mode_reg;
   logic [CNT_W-1:0]         step_cnt_reg;
   logic [CNT_W-1:0]         pulse_cnt_reg;
   logic                     step_done;
   logic                     interval_tick;
   logic                     dram_refreshing;
   logic                     pulse_active;
   logic                     sel_n_next;
   logic                     sel2_n_next;
   logic                     ras_n_next;
   logic                     ras2_n_next;
   logic                     sel_n_reg;
   logic                     sel2_n_reg;
   logic                     ras_n_reg;
   logic                     ras2_n_reg;
   logic                     wr_ctrl;
   logic                     wr_base;
   logic                     wr_shctl;
   logic                     wr_status;
   logic                     wr_mask;
   logic [IRQ_WIDTH-1:0]     irq_events;
   logic [7:0]               rdata_next;

   assign wr_ctrl   = reg_wr_in && (reg_addr_in == SUSP_REFRESH_CTRL_IDX);
   assign wr_base   = reg_wr_in && (reg_addr_in == SHADOW_BASE_IDX);
   assign wr_shctl  = reg_wr_in && (reg_addr_in == SHADOW_CTRL_IDX);
   assign wr_status = reg_wr_in && (reg_addr_in == IRQ_STATUS_IDX);
   assign wr_mask   = reg_wr_in && (reg_addr_in == IRQ_MASK_IDX);

   ////////////////////////////////////////////////////////////////////////////
   // Suspend refresh control: mode and slow bit are writable, the flag is not.
   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         suspend_refresh_mode_reg <= ssr_mode_t'(MODE_RESET);
         slow_refresh_select_reg  <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         suspend_refresh_mode_reg <=
            ssr_mode_t'(reg_wdata_in[MODE_HI_BIT:MODE_LO_BIT]);
         slow_refresh_select_reg  <= reg_wdata_in[SLOW_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shadow base and shadow control registers.
   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         shadow_base_bits_reg <= SHADOW_BASE_RESET;
      end
      else if (wr_base)
      begin
         shadow_base_bits_reg <= reg_wdata_in;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         shadow_write_enable_reg <= 1'b0;
         shadow_read_enable_reg  <= 1'b0;
         eseg_wp_reg             <= 1'b0;
         dseg_wp_reg             <= 1'b0;
      end
      else if (wr_shctl)
      begin
         shadow_write_enable_reg <= reg_wdata_in[SH_WE_BIT];
         shadow_read_enable_reg  <= reg_wdata_in[SH_RE_BIT];
         eseg_wp_reg             <= reg_wdata_in[ESEG_WP_BIT];
         dseg_wp_reg             <= reg_wdata_in[DSEG_WP_BIT];
      end
   end

   assign eseg_wp_out = eseg_wp_reg;
   assign dseg_wp_out = dseg_wp_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Suspend sequencer: each pin step waits one step time.
   assign step_done = (step_cnt_reg == CNT_ZERO);

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_ACTIVE:
         begin
            if (suspend_in)
            begin
               state_next = ST_SEL1;
            end
         end
         ST_SEL1:
         begin
            if (step_done)
            begin
               state_next = ST_SEL2;
            end
         end
         ST_SEL2:
         begin
            if (step_done)
            begin
               state_next = (run_mode_reg == MODE_SELF_DRAM) ? ST_RAS1 : ST_HOLD;
            end
         end
         ST_RAS1:
         begin
            if (step_done)
            begin
               state_next = ST_HOLD;
            end
         end
         ST_HOLD:
         begin
            if (!suspend_in)
            begin
               state_next = ST_EXIT1;
            end
         end
         ST_EXIT1:
         begin
            if (step_done)
            begin
               state_next = ST_EXIT2;
            end
         end
         ST_EXIT2:
         begin
            if (step_done)
            begin
               state_next = ST_ACTIVE;
            end
         end
         default:
         begin
            state_next = ST_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         state_reg <= ST_ACTIVE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // The mode is caught on suspend entry so a late write cannot upset a running sequence.
   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         run_mode_reg <= MODE_SRAM;
      end
      else if (state_reg == ST_ACTIVE)
      begin
         run_mode_reg <= suspend_refresh_mode_reg;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         step_cnt_reg <= CNT_ZERO;
      end
      else if (state_next != state_reg)
      begin
         step_cnt_reg <= CNT_W'(STEP_CYC - 1);
      end
      else if (!step_done)
      begin
         step_cnt_reg <= step_cnt_reg - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Standard DRAM refresh pulses on both row strobes.
   assign dram_refreshing = (state_reg == ST_HOLD) && (run_mode_reg == MODE_DRAM);

   ssr_interval_timer u_interval
   (
      .ref_clk_in (ref_clk_in),
      .resetn_in  (resetn_in),
      .enable_in  (dram_refreshing),
      .slow_in    (slow_refresh_select_reg),
      .tick_out   (interval_tick)
   );

   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in || !dram_refreshing)
      begin
         pulse_cnt_reg <= CNT_ZERO;
      end
      else if (interval_tick)
      begin
         pulse_cnt_reg <= CNT_W'(RAS_PULSE_CYC);
      end
      else if (pulse_cnt_reg != CNT_ZERO)
      begin
         pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
      end
   end

   assign pulse_active = (pulse_cnt_reg != CNT_ZERO);

   ////////////////////////////////////////////////////////////////////////////
   // Pin decode; SRAM mode leaves every pin negated.
   always_comb
   begin
      sel_n_next  = 1'b1;
      sel2_n_next = 1'b1;
      ras_n_next  = 1'b1;
      ras2_n_next = 1'b1;
      if (run_mode_reg != MODE_SRAM)
      begin
         sel_n_next  = (state_reg == ST_ACTIVE);
         sel2_n_next = (state_reg == ST_ACTIVE) || (state_reg == ST_SEL1) ||
                       (state_reg == ST_EXIT2);
      end
      if (run_mode_reg == MODE_SELF_DRAM)
      begin
         ras_n_next  = !((state_reg == ST_RAS1) || (state_reg == ST_HOLD));
         ras2_n_next = (state_reg != ST_HOLD);
      end
      else if (run_mode_reg == MODE_DRAM)
      begin
         ras_n_next  = !pulse_active;
         ras2_n_next = !pulse_active;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         sel_n_reg  <= 1'b1;
         sel2_n_reg <= 1'b1;
         ras_n_reg  <= 1'b1;
         ras2_n_reg <= 1'b1;
      end
      else
      begin
         sel_n_reg  <= sel_n_next;
         sel2_n_reg <= sel2_n_next;
         ras_n_reg  <= ras_n_next;
         ras2_n_reg <= ras2_n_next;
      end
   end

   assign refresh_select_n_out        = sel_n_reg;
   assign second_refresh_select_n_out = sel2_n_reg;
   assign row_strobe_n_out            = ras_n_reg;
   assign second_row_strobe_n_out     = ras2_n_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Refresh ownership flag; only the sequencer moves it.
   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         refresh_complete_flag_reg <= 1'b0;
      end
      else
      begin
         refresh_complete_flag_reg <= (state_reg == ST_ACTIVE) &&
                                      !suspend_in;
      end
   end

   assign refresh_complete_out = refresh_complete_flag_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: flag rise and fall are sticky, write one to clear, set wins.
   assign irq_events[IRQ_DONE_BIT] = (state_reg == ST_ACTIVE) && !suspend_in &&
                                     !refresh_complete_flag_reg;
   assign irq_events[IRQ_LOST_BIT] = !((state_reg == ST_ACTIVE) && !suspend_in) &&
                                     refresh_complete_flag_reg;

   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         irq_status_reg <= '0;
      end
      else
      begin
         irq_status_reg <= (irq_status_reg &
                            ~(wr_status ? reg_wdata_in[IRQ_WIDTH-1:0] : '0)) |
                           irq_events;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         irq_mask_reg <= '0;
      end
      else if (wr_mask)
      begin
         irq_mask_reg <= reg_wdata_in[IRQ_WIDTH-1:0];
      end
   end

   assign irq_out = |(irq_status_reg & irq_mask_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Read port: data stand the cycle after the read strobe only.
   always_comb
   begin
      rdata_next = BYTE_ZERO;
      case (reg_addr_in)
         SUSP_REFRESH_CTRL_IDX:
         begin
            rdata_next[MODE_HI_BIT:MODE_LO_BIT] = suspend_refresh_mode_reg;
            rdata_next[SLOW_BIT]                = slow_refresh_select_reg;
            rdata_next[DONE_BIT]                = refresh_complete_flag_reg;
         end
         SHADOW_BASE_IDX:
         begin
            rdata_next = shadow_base_bits_reg;
         end
         SHADOW_CTRL_IDX:
         begin
            rdata_next[SH_WE_BIT]   = shadow_write_enable_reg;
            rdata_next[SH_RE_BIT]   = shadow_read_enable_reg;
            rdata_next[ESEG_WP_BIT] = eseg_wp_reg;
            rdata_next[DSEG_WP_BIT] = dseg_wp_reg;
         end
         IRQ_STATUS_IDX:
         begin
            rdata_next[IRQ_WIDTH-1:0] = irq_status_reg;
         end
         IRQ_MASK_IDX:
         begin
            rdata_next[IRQ_WIDTH-1:0] = irq_mask_reg;
         end
         default:
         begin
            rdata_next = BYTE_ZERO;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in || !reg_rd_in)
      begin
         rdata_reg <= BYTE_ZERO;
      end
      else
      begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata_out = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // BIOS shadow address steering.
   ssr_shadow_map u_shadow
   (
      .ref_clk_in  (ref_clk_in),
      .resetn_in   (resetn_in),
      .req_in      (mem_req_in),
      .write_in    (mem_write_in),
      .addr_in     (mem_addr_in),
      .base_in     (shadow_base_bits_reg),
      .write_en_in (shadow_write_enable_reg),
      .read_en_in  (shadow_read_enable_reg),
      .addr_out    (mem_addr_out),
      .rom_sel_out (rom_sel_out),
      .ram_sel_out (ram_sel_out)
   );

endmodule : ssr_ctrl

`default_nettype wire

/* File: rtl/ssr_pkg.sv */
`default_nettype none

package ssr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indexes.
   localparam logic [7:0] SUSP_REFRESH_CTRL_IDX = 8'hE4;
   localparam logic [7:0] SHADOW_BASE_IDX       = 8'hE8;
   localparam logic [7:0] SHADOW_CTRL_IDX       = 8'hE9;
   localparam logic [7:0] IRQ_STATUS_IDX        = 8'hF0;
   localparam logic [7:0] IRQ_MASK_IDX          = 8'hF1;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values.
   localparam int MODE_HI_BIT     = 7;
   localparam int MODE_LO_BIT     = 6;
   localparam int SLOW_BIT        = 5;
   localparam int DONE_BIT        = 4;
   localparam int SH_WE_BIT       = 7;
   localparam int SH_RE_BIT       = 6;
   localparam int ESEG_WP_BIT     = 1;
   localparam int DSEG_WP_BIT     = 0;
   localparam int IRQ_DONE_BIT    = 0;
   localparam int IRQ_LOST_BIT    = 1;
   localparam int IRQ_WIDTH       = 2;

   localparam logic [1:0] MODE_RESET       = 2'h0;
   localparam logic [7:0] SHADOW_BASE_RESET = 8'h0F;
   localparam logic [7:0] BYTE_ZERO        = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Memory map of the shadowed BIOS window.
   localparam logic [7:0] BIOS_SEG_HI = 8'h0F;

   ////////////////////////////////////////////////////////////////////////////
   // Modes and sequencer states.
   typedef enum logic [1:0] {
      MODE_SRAM      = 2'b00,
      MODE_PSRAM     = 2'b01,
      MODE_DRAM      = 2'b10,
      MODE_SELF_DRAM = 2'b11
   } ssr_mode_t;

   typedef enum logic [2:0] {
      ST_ACTIVE = 3'b000,
      ST_SEL1   = 3'b001,
      ST_SEL2   = 3'b010,
      ST_RAS1   = 3'b011,
      ST_HOLD   = 3'b100,
      ST_EXIT1  = 3'b101,
      ST_EXIT2  = 3'b110
   } ssr_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int CLK_MHZ        = 20;
   localparam int FAST_US        = 15;
   localparam int SLOW_US        = 120;
   localparam int STEP_NS        = 1000;
   localparam int RAS_PULSE_NS   = 200;
   localparam int CNT_W          = 12;
   localparam int FAST_CYC       = FAST_US * CLK_MHZ;
   localparam int SLOW_CYC       = SLOW_US * CLK_MHZ;
   localparam int STEP_CYC       = (STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int RAS_PULSE_CYC  = (RAS_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

endpackage : ssr_pkg

`default_nettype wire

/* File: rtl/ssr_interval_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module ssr_interval_timer
(
   input  wire logic ref_clk_in,
   input  wire logic resetn_in,
   input  wire logic enable_in,
   input  wire logic slow_in,
   output logic      tick_out
);
   import ssr_pkg::*;

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] reload;

   assign reload = slow_in ? CNT_W'(SLOW_CYC - 1) : CNT_W'(FAST_CYC - 1);

   // Pulses tick on the first enabled cycle, then counts one refresh interval and pulses tick at its end.
   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in || !enable_in)
      begin
         count_reg <= CNT_ZERO;
         tick_out  <= 1'b0;
      end
      else if (count_reg == CNT_ZERO)
      begin
         count_reg <= reload;
         tick_out  <= 1'b1;
      end
      else
      begin
         count_reg <= count_reg - 1'b1;
         tick_out  <= 1'b0;
      end
   end

endmodule : ssr_interval_timer

`default_nettype wire

/* File: rtl/ssr_shadow_map.sv */
`timescale 1ns/1ps
`default_nettype none

module ssr_shadow_map
(
   input  wire logic        ref_clk_in,
   input  wire logic        resetn_in,
   input  wire logic        req_in,
   input  wire logic        write_in,
   input  wire logic [23:0] addr_in,
   input  wire logic [7:0]  base_in,
   input  wire logic        write_en_in,
   input  wire logic        read_en_in,
   output logic [23:0]      addr_out,
   output logic             rom_sel_out,
   output logic             ram_sel_out
);
   import ssr_pkg::*;

   logic in_bios;
   logic redirect;

   assign in_bios  = (addr_in[23:16] == BIOS_SEG_HI);
   assign redirect = in_bios && (write_in ? write_en_in : read_en_in);

   // Moves the BIOS window onto the programmed 64 Kbyte shadow segment.
   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in || !req_in)
      begin
         addr_out    <= 24'h000000;
         rom_sel_out <= 1'b0;
         ram_sel_out <= 1'b0;
      end
      else
      begin
         addr_out    <= redirect ? {base_in, addr_in[15:0]} : addr_in;
         rom_sel_out <= in_bios && !redirect;
         ram_sel_out <= !in_bios || redirect;
      end
   end

endmodule : ssr_shadow_map

`default_nettype wire

/* File: verif/ssr_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module ssr_ctrl_sva
(
   input wire logic        ref_clk_in,
   input wire logic        resetn_in,
   input wire logic        suspend_in,
   input wire logic        mem_req_in,
   input wire logic [23:0] mem_addr_in,
   input wire logic [23:0] mem_addr_out,
   input wire logic        rom_sel_out,
   input wire logic        ram_sel_out,
   input wire logic        refresh_select_n_out,
   input wire logic        second_refresh_select_n_out,
   input wire logic        row_strobe_n_out,
   input wire logic        second_row_strobe_n_out,
   input wire logic        refresh_complete_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   logic [3:0] pins;
   assign pins = {refresh_select_n_out, second_refresh_select_n_out,
                  row_strobe_n_out, second_row_strobe_n_out};
   a_flag_low_susp: assert property (suspend_in |=> !refresh_complete_out)
      else $error("flag high in suspend");
   a_flag_pins_idle: assert property (refresh_complete_out |-> pins == 4'hF)
      else $error("pin low while flag set");
   a_flag_return: assert property (disable iff (!resetn_in || suspend_in)
      $fell(suspend_in) |-> ##[1:200] refresh_complete_out) else $error("flag not back");
   a_select_order: assert property (!pins[2] |-> !pins[3])
      else $error("second select before first");
   a_row_needs_sel: assert property (pins[1:0] != 2'b11 |-> pins[3:2] == 2'b00)
      else $error("row strobe without selects");
   a_row_order: assert property (!pins[0] |-> !pins[1])
      else $error("second row strobe first");
   a_pulse_width: assert property (disable iff (!resetn_in || !suspend_in)
      $fell(pins[1]) && $fell(pins[0]) |-> !pins[1] [*4] ##1 pins[1])
      else $error("refresh pulse width");
   a_outside_pass: assert property (mem_req_in && mem_addr_in[23:16] != 8'h0F |=>
      ram_sel_out && !rom_sel_out && mem_addr_out == $past(mem_addr_in))
      else $error("outside address changed");
   a_bios_route: assert property (mem_req_in && mem_addr_in[23:16] == 8'h0F |=>
      (rom_sel_out ^ ram_sel_out) && mem_addr_out[15:0] == $past(mem_addr_in[15:0]))
      else $error("bios access misrouted");
endmodule : ssr_ctrl_sva
bind ssr_ctrl ssr_ctrl_sva u_sva (.*);
`default_nettype wire

/* File: verif/ssr_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Refresh side of the memory array: counts row refresh pulses and their spacing.
module ssr_mem_model
(
   input  wire logic ref_clk_in,
   input  wire logic resetn_in,
   input  wire logic sel_n_in,
   input  wire logic sel2_n_in,
   input  wire logic row_n_in,
   output int        pulse_count_out,
   output int        gap_out,
   output logic      order_ok_out
);
   int   since_reg;
   logic row_prev_reg;
   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         row_prev_reg    <= 1'b1;
         since_reg       <= 0;
         pulse_count_out <= 0;
         gap_out         <= 0;
         order_ok_out    <= 1'b1;
      end
      else
      begin
         row_prev_reg <= row_n_in;
         since_reg    <= since_reg + 1;
         if (row_prev_reg && !row_n_in)
         begin
            pulse_count_out <= pulse_count_out + 1;
            gap_out         <= since_reg;
            since_reg       <= 1;
         end
         if (!sel2_n_in && sel_n_in)
            order_ok_out <= 1'b0;
      end
   end
endmodule : ssr_mem_model
`default_nettype wire

/* File: verif/ssr_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ssr_ctrl_test;
   import ssr_pkg::*;
   logic ref_clk_in, resetn_in, reg_wr_in, reg_rd_in, suspend_in, mem_req_in, mem_write_in;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, b, c;
   logic [23:0] mem_addr_in, mem_addr_out, a;
   logic rom_sel_out, ram_sel_out, eseg_wp_out, dseg_wp_out, irq_out, refresh_complete_out;
   logic refresh_select_n_out, second_refresh_select_n_out;
   logic row_strobe_n_out, second_row_strobe_n_out, ord_ok;
   logic [3:0] pins;
   int pcnt, gap, err_count, samples_checked, cycles, n;
   assign pins = {refresh_select_n_out, second_refresh_select_n_out,
                  row_strobe_n_out, second_row_strobe_n_out};
   ssr_ctrl DUT (.*);
   ssr_mem_model u_mem (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .sel_n_in(refresh_select_n_out), .sel2_n_in(second_refresh_select_n_out),
      .row_n_in(row_strobe_n_out), .pulse_count_out(pcnt), .gap_out(gap),
      .order_ok_out(ord_ok));
   initial
   begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   task automatic check(input logic [25:0] seen, input logic [25:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize;
      $display("compares %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
      @(posedge ref_clk_in);
      reg_addr_in  <= ad;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
      #1;
   endtask : wr_reg
   task automatic chk_reg(input logic [7:0] ad, input logic [7:0] e);
      @(posedge ref_clk_in);
      reg_addr_in <= ad;
      reg_rd_in   <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      #1;
      check({18'h0, reg_rdata_out}, {18'h0, e});
   endtask : chk_reg
   function automatic logic [25:0] exp_map(input logic [23:0] ad, input logic w,
                                           input logic [7:0] bs, input logic [1:0] en);
      if (ad[23:16] != 8'h0F)
         return {2'b01, ad};
      if (w ? en[1] : en[0])
         return {2'b01, bs, ad[15:0]};
      return {2'b10, ad};
   endfunction : exp_map
   task automatic mem(input logic [23:0] ad, input logic w, input logic [7:0] bs,
                      input logic [1:0] en);
      @(posedge ref_clk_in);
      mem_req_in   <= 1'b1;
      mem_write_in <= w;
      mem_addr_in  <= ad;
      @(posedge ref_clk_in);
      mem_req_in <= 1'b0;
      #1;
      check({rom_sel_out, ram_sel_out, mem_addr_out}, exp_map(ad, w, bs, en));
   endtask : mem
   // Enters suspend in one mode, checks the pins and the flag, then leaves it.
   task automatic run_mode(input logic [1:0] m, input logic slow);
      int i;
      int base;
      logic [3:0] e;
      logic [3:0] k;
      e = (m == 2'b00) ? 4'hF : ((m == 2'b01) ? 4'h3 : 4'h0);
      k = (m == 2'b10) ? 4'hC : 4'hF;
      wr_reg(SUSP_REFRESH_CTRL_IDX, {m, slow, 5'h00});
      @(posedge ref_clk_in);
      suspend_in <= 1'b1;
      base = pcnt;
      for (i = 0; i < 300 && (refresh_complete_out !== 1'b0 || (pins & k) !== e); i++)
         @(posedge ref_clk_in);
      check(pins & k, e);
      chk_reg(SUSP_REFRESH_CTRL_IDX, {m, slow, 5'h00});
      for (i = 0; i < 6000 && m == 2'b10 && pcnt < base + 2; i++)
         @(posedge ref_clk_in);
      if (m == 2'b10)
         check(gap, (slow ? SLOW_US : FAST_US) * CLK_MHZ);
      @(posedge ref_clk_in);
      suspend_in <= 1'b0;
      for (i = 0; i < 300 && refresh_complete_out !== 1'b1; i++)
         @(posedge ref_clk_in);
      check({refresh_complete_out, pins}, 5'h1F);
   endtask : run_mode
   always @(posedge ref_clk_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         summarize();
      end
   end
   initial
   begin
      {resetn_in, reg_wr_in, reg_rd_in, suspend_in, mem_req_in, mem_write_in} = 6'h00;
      {reg_addr_in, reg_wdata_in, mem_addr_in} = 40'h0;
      {err_count, samples_checked, cycles} = 0;
      void'($urandom(51));
      repeat (6) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      chk_reg(SUSP_REFRESH_CTRL_IDX, 8'h10);
      chk_reg(SHADOW_BASE_IDX, 8'h0F);
      chk_reg(SHADOW_CTRL_IDX, 8'h00);
      chk_reg(8'h55, 8'h00);
      wr_reg(SUSP_REFRESH_CTRL_IDX, 8'h0F);
      chk_reg(SUSP_REFRESH_CTRL_IDX, 8'h10);
      for (n = 0; n < 5; n++)
         run_mode((n < 3) ? n[1:0] : ((n == 3) ? 2'b10 : 2'b11), n == 3);
      check(ord_ok, 1'b1);
      chk_reg(IRQ_STATUS_IDX, 8'h03);
      wr_reg(IRQ_MASK_IDX, 8'h02);
      check(irq_out, 1'b1);
      wr_reg(IRQ_STATUS_IDX, 8'h02);
      check(irq_out, 1'b0);
      chk_reg(IRQ_STATUS_IDX, 8'h01);
      wr_reg(SHADOW_BASE_IDX, 8'hFF);
      wr_reg(SHADOW_CTRL_IDX, 8'h80);
      mem(24'h0FFFFF, 1'b1, 8'hFF, 2'b10);
      mem(24'h0F0000, 1'b0, 8'hFF, 2'b10);
      wr_reg(SHADOW_CTRL_IDX, 8'h00);
      mem(24'h0F8000, 1'b1, 8'hFF, 2'b00);
      wr_reg(SHADOW_CTRL_IDX, 8'h40);
      mem(24'h0F0000, 1'b0, 8'hFF, 2'b01);
      mem(24'h0EFFFF, 1'b0, 8'hFF, 2'b01);
      for (n = 0; n < 40; n++)
      begin
         b = $urandom;
         c = $urandom;
         a = $urandom;
         if (n % 2)
            a[23:16] = 8'h0F;
         wr_reg(SHADOW_BASE_IDX, b);
         wr_reg(SHADOW_CTRL_IDX, c);
         chk_reg(SHADOW_BASE_IDX, b);
         chk_reg(SHADOW_CTRL_IDX, c & 8'hC3);
         check({eseg_wp_out, dseg_wp_out}, c[1:0]);
         mem(a, n[2], b, c[7:6]);
      end
      // A short reset in mid-run must bring the shadow base, shadow control and suspend refresh control registers back to their reset values.
      @(posedge ref_clk_in);
      resetn_in <= 1'b0;
      @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      chk_reg(SHADOW_BASE_IDX, 8'h0F);
      chk_reg(SHADOW_CTRL_IDX, 8'h00);
      chk_reg(SUSP_REFRESH_CTRL_IDX, 8'h10);
      summarize();
   end
endmodule : ssr_ctrl_test
`default_nettype wire
